// [rtl/secure_status_error_regs.sv]
// Secure access control, enable change status and imprecise error
// register bank, with a small maskable interrupt block.
// Assumes the master drives one-cycle strobes with a secure attribute,
// and that the snoop fabric reports enable changes and AC traffic.
//
// Overview of operation
// R1 - Secure control written only by secure writes
// R2 - Override bit resets 0; 1 opens non-secure
// R3 - Pending reads 1 until enable changes apply
// R4 - Pending also 1 while disabled slave has AC
// R5 - Pending in bit 0, resets 0, read-only
// R6 - One sticky error flag per interface
// R7 - Flag stays set until one written
// R8 - Error interrupt low while any flag set
// R9 - Error log secure only unless override set
// R10 - Error flags reset to zero
// R11 - Reserved bits read zero; zero writes ignored
module secure_status_error_regs
	import coh_regs_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Register port
	input  wire reg_req_s           req,
	output logic      [DATA_W-1:0]  rdata,
	// Snoop fabric status
	input  wire logic               enables_modified,
	input  wire logic               enables_applied,
	input  wire logic [NUM_SLV-1:0] slave_snoop_disabled,
	input  wire logic [NUM_SLV-1:0] ac_outstanding,
	// Imprecise error responses
	input  wire err_event_s         err_event,
	// Interrupts
	output logic                    error_interrupt_low,
	output logic                    irq
);

	// Control state of the bank
	typedef struct packed {
		logic              override;
		logic              change;
		logic              pending;
		logic [1:0]        irq_stat;
		logic [1:0]        irq_mask;
		logic [DATA_W-1:0] rdata;
		logic              err_low;
		logic              irq;
	} ctl_state_s;

	ctl_state_s st_ff;
	ctl_state_s nxt_st;

	logic              rst_meta_ff;
	logic              rst_sync_ff;
	logic              rst_n;
	logic [NUM_IF-1:0] flags;
	logic              allowed;
	logic              wr_sec_ctrl;
	logic              wr_err_log;
	logic              wr_irq_stat;
	logic              wr_irq_mask;
	logic              ac_busy;
	logic [1:0]        irq_events;
	logic [DATA_W-1:0] rd_value;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign rst_n = rst_sync_ff;

	// Access decode; the override only widens, never narrows, access
	assign allowed = access_ok(req.secure, st_ff.override); // R9
	assign wr_sec_ctrl = req.wr && req.secure &&
	                     (req.addr == OFS_SEC_CTRL); // R1
	assign wr_err_log = req.wr && allowed &&
	                    (req.addr == OFS_ERR_LOG); // R9
	assign wr_irq_stat = req.wr && allowed && (req.addr == OFS_IRQ_STAT);
	assign wr_irq_mask = req.wr && allowed && (req.addr == OFS_IRQ_MASK);

	// A disabled slave still draining AC requests keeps things pending
	assign ac_busy = |(slave_snoop_disabled & ac_outstanding); // R4

	// Sticky error flags live in their own module
	imprecise_error_flags u_flags (
		.clock    (clock),
		.rst_n    (rst_n),
		.set_ev   (err_event),
		.clr_en   (wr_err_log),
		.clr_mask (unpack_log(req.wdata)),
		.flags    (flags)
	);

	// Read mux; denied reads and unmapped offsets return zero
	always_comb begin
		rd_value = '0;
		case (req.addr)
			OFS_SEC_CTRL: begin
				rd_value[BIT_OVERRIDE] = st_ff.override; // R11
			end
			OFS_STATUS: begin
				rd_value[BIT_PENDING] = st_ff.pending; // R5
			end
			OFS_ERR_LOG: begin
				if (allowed) begin
					rd_value = pack_log(flags); // R9 R11
				end
			end
			OFS_IRQ_STAT: begin
				if (allowed) begin
					rd_value[1:0] = st_ff.irq_stat;
				end
			end
			OFS_IRQ_MASK: begin
				if (allowed) begin
					rd_value[1:0] = st_ff.irq_mask;
				end
			end
			default: begin
				rd_value = '0;
			end
		endcase
	end

	// Next state of the bank control registers; the error flags update in u_flags
	always_comb begin
		nxt_st = st_ff;
		// Only secure writers may move the override
		if (wr_sec_ctrl) begin
			nxt_st.override = req.wdata[BIT_OVERRIDE]; // R1 R2
		end
		// A fresh change wins over an apply report in the same cycle
		if (enables_modified) begin
			nxt_st.change = 1'b1; // R3
		end else if (enables_applied) begin
			nxt_st.change = 1'b0; // R3
		end
		// Status writes are simply dropped: nothing decodes them
		nxt_st.pending = nxt_st.change | ac_busy; // R3 R4 R5
		// Interrupt sources: any new error, and pending change completion.
		// Built here so the fall of pending needs no loop between processes
		irq_events = '0;
		irq_events[BIT_IRQ_ERR] = |err_event;
		irq_events[BIT_IRQ_DONE] = st_ff.pending && !nxt_st.pending;
		// Interrupt status: write one to clear, events win the tie
		nxt_st.irq_stat = st_ff.irq_stat &
		                  ~(wr_irq_stat ? req.wdata[1:0] : 2'h0);
		nxt_st.irq_stat = nxt_st.irq_stat | irq_events;
		if (wr_irq_mask) begin
			nxt_st.irq_mask = req.wdata[1:0];
		end
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
		// Read data stands for exactly one cycle after the strobe
		nxt_st.rdata = req.rd ? rd_value : RST_RDATA;
		// Lags the flags by one cycle, keeping the output a flop
		nxt_st.err_low = ~(|flags); // R8
	end

	// Bank control state registers here; the error flags sit in u_flags
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff.override <= RST_OVERRIDE; // R2
			st_ff.change <= RST_PENDING;
			st_ff.pending <= RST_PENDING; // R5
			st_ff.irq_stat <= RST_IRQ;
			st_ff.irq_mask <= RST_IRQ;
			st_ff.rdata <= RST_RDATA;
			st_ff.err_low <= 1'b1;
			st_ff.irq <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign error_interrupt_low = st_ff.err_low;
	assign irq = st_ff.irq;

	// Checks on the bank's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence ns_write(logic [ADDR_W-1:0] ofs);
		req.wr && !req.secure && (req.addr == ofs);
	endsequence

	sequence sec_write(logic [ADDR_W-1:0] ofs);
		req.wr && req.secure && (req.addr == ofs);
	endsequence

	sequence log_read;
		req.rd && (req.addr == OFS_ERR_LOG);
	endsequence

	property hold_override;
		ns_write(OFS_SEC_CTRL) |=> $stable(st_ff.override);
	endproperty

	property load_override;
		sec_write(OFS_SEC_CTRL)
			|=> st_ff.override == $past(req.wdata[BIT_OVERRIDE]);
	endproperty

	property flags_kept(logic cond);
		cond |=> (flags & $past(flags)) == $past(flags);
	endproperty

	// A read strobe at one offset
	sequence reg_read(logic [ADDR_W-1:0] ofs);
		req.rd && (req.addr == ofs);
	endsequence

	// Apply report with nothing left to drain
	sequence apply_only;
		enables_applied && !enables_modified && !ac_busy;
	endsequence

	// Ones written to the log, minus errors arriving in the same cycle
	property flags_cleared;
		wr_err_log
			|=> (flags & $past(unpack_log(req.wdata))
			     & ~$past({err_event.slv, err_event.mst})) == '0;
	endproperty

	ns_write_blocked_a: assert property (hold_override) // R1
		else $error("non-secure write moved the override");

	override_load_a: assert property (load_override) // R2
		else $error("override readback differs from secure write");

	pending_set_a: assert property ( // R3
		enables_modified |=> st_ff.pending && st_ff.change)
		else $error("pending not raised after enable change");

	ac_pending_a: assert property ( // R4
		ac_busy |=> st_ff.pending)
		else $error("pending low while disabled slave has AC");

	status_read_a: assert property ( // R5
		req.rd && (req.addr == OFS_STATUS)
			|=> rdata == {31'h0000_0000, $past(st_ff.pending)})
		else $error("status read shows wrong value");

	error_set_a: assert property ( // R6
		|err_event |=> (flags & $past(err_event)) == $past(err_event))
		else $error("error event did not set its flag");

	error_hold_a: assert property ( // R7
		flags_kept(!wr_err_log))
		else $error("flag dropped without a clearing write");

	irq_low_a: assert property ( // R8
		(flags != '0) |=> !error_interrupt_low ##1 1'b1)
		else $error("error interrupt not low with flags set");

	ns_log_a: assert property ( // R9
		ns_write(OFS_ERR_LOG) ##0 !st_ff.override
			|=> (flags & $past(flags)) == $past(flags))
		else $error("denied write cleared an error flag");

	log_read_a: assert property ( // R10 R11
		log_read ##0 allowed |=> rdata == pack_log($past(flags)))
		else $error("error log read shows wrong layout");

	// Pending status: ways out, tie, hold, idle, status writes and reserved bits; control readback
	pending_drop_a: assert property ( // R3
		apply_only |=> !st_ff.pending)
		else $error("pending stayed high after changes applied");

	pending_tie_a: assert property ( // R3
		enables_modified && enables_applied |=> st_ff.pending)
		else $error("pending dropped on a modify and apply tie");

	pending_hold_a: assert property ( // R3
		st_ff.change && !enables_applied |=> st_ff.pending)
		else $error("pending fell before changes were applied");

	pending_idle_a: assert property ( // R3
		!st_ff.change && !enables_modified && !ac_busy
			|=> !st_ff.pending)
		else $error("pending high with nothing outstanding");

	status_write_a: assert property ( // R5
		req.wr && (req.addr == OFS_STATUS)
			&& !enables_modified && !enables_applied
			|=> st_ff.change == $past(st_ff.change))
		else $error("status write moved the pending state");

	status_wi_a: assert property ( // R5 R11
		reg_read(OFS_STATUS) |=> rdata[DATA_W-1:BIT_PENDING+1] == '0)
		else $error("status read shows reserved bits set");

	ctrl_read_a: assert property ( // R2 R11
		reg_read(OFS_SEC_CTRL)
			|=> rdata == {31'h0000_0000, $past(st_ff.override)})
		else $error("secure control read shows wrong value");

	// Error log: clears, zero writes, interrupt release, denial and reserved bits
	flag_clear_a: assert property (flags_cleared) // R7
		else $error("written one did not clear its flag");

	zero_write_a: assert property ( // R11
		flags_kept(wr_err_log && (unpack_log(req.wdata) == '0)))
		else $error("zero write cleared an error flag");

	irq_high_a: assert property ( // R8
		(flags == '0) |=> error_interrupt_low)
		else $error("error interrupt low with all flags clear");

	log_denied_a: assert property ( // R9
		reg_read(OFS_ERR_LOG) ##0 !allowed |=> rdata == '0)
		else $error("denied error log read returned data");

	log_reserved_a: assert property ( // R11
		log_read |=> (rdata[DATA_W-1:LSB_SLV_ERR+NUM_SLV] == '0)
			&& (rdata[LSB_SLV_ERR-1:LSB_MST_ERR+NUM_MST] == '0))
		else $error("error log read shows reserved bits set");

	// Read data stand only in the cycle after a read strobe
	rdata_idle_a: assert property (
		!req.rd |=> rdata == '0)
		else $error("read data present without a read strobe");

	// Interrupt block: sources, clears and the security gate
	irq_event_a: assert property (
		|err_event |=> st_ff.irq_stat[BIT_IRQ_ERR])
		else $error("error event did not set interrupt status");

	irq_done_a: assert property (
		st_ff.pending ##1 !st_ff.pending
			|-> st_ff.irq_stat[BIT_IRQ_DONE])
		else $error("pending fall did not set interrupt status");

	irq_clear_a: assert property (
		wr_irq_stat && req.wdata[BIT_IRQ_ERR] && !(|err_event)
			|=> !st_ff.irq_stat[BIT_IRQ_ERR])
		else $error("interrupt status bit survived its clear");

	mask_denied_a: assert property (
		req.wr && !allowed && (req.addr == OFS_IRQ_MASK)
			|=> $stable(st_ff.irq_mask))
		else $error("denied write moved the interrupt mask");

endmodule

// [include/coh_regs_pkg.sv]
// Shared constants, carrier structs and decode helpers for the
// secure, status and imprecise error register bank.
// Assumes a single 200 MHz clock and a plain strobe register port.
package coh_regs_pkg;

	// Register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_SLV = 5;
	localparam int NUM_MST = 3;
	localparam int NUM_IF = NUM_SLV + NUM_MST;

	// Byte offsets of the registers
	localparam logic [ADDR_W-1:0] OFS_SEC_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ERR_LOG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

	// Field positions
	localparam int BIT_OVERRIDE = 0;
	localparam int BIT_PENDING = 0;
	localparam int LSB_SLV_ERR = 16;
	localparam int LSB_MST_ERR = 0;
	localparam int BIT_IRQ_ERR = 0;
	localparam int BIT_IRQ_DONE = 1;

	// Values after reset
	localparam logic RST_OVERRIDE = 1'b0;
	localparam logic RST_PENDING = 1'b0;
	localparam logic [NUM_IF-1:0] RST_ERR_FLAGS = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

	// One register access from a system master
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
		logic              secure;
	} reg_req_s;

	// Imprecise error responses seen this cycle, one bit per interface
	typedef struct packed {
		logic [NUM_SLV-1:0] slv;
		logic [NUM_MST-1:0] mst;
	} err_event_s;

	// Access is allowed when secure, or when the override opens it up
	function automatic logic access_ok(input logic secure,
	                                   input logic override);
		return secure | override;
	endfunction

	// Place the flag vector into its register layout
	function automatic logic [DATA_W-1:0] pack_log(
			input logic [NUM_IF-1:0] flags);
		logic [DATA_W-1:0] word;
		word = '0;
		word[LSB_SLV_ERR +: NUM_SLV] = flags[NUM_IF-1:NUM_MST];
		word[LSB_MST_ERR +: NUM_MST] = flags[NUM_MST-1:0];
		return word;
	endfunction

	// Pull the flag positions back out of a written word
	function automatic logic [NUM_IF-1:0] unpack_log(
			input logic [DATA_W-1:0] word);
		return {word[LSB_SLV_ERR +: NUM_SLV], word[LSB_MST_ERR +: NUM_MST]};
	endfunction

endpackage

// [rtl/imprecise_error_flags.sv]
// Sticky imprecise error flags, one per slave and master interface.
// Assumes set and clear requests are synchronous to clock.
module imprecise_error_flags
	import coh_regs_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Events and clears
	input  wire err_event_s        set_ev,
	input  wire logic              clr_en,
	input  wire logic [NUM_IF-1:0] clr_mask,
	// Flag state
	output logic      [NUM_IF-1:0] flags
);

	typedef struct packed {
		logic [NUM_IF-1:0] flags;
	} flag_state_s;

	flag_state_s st_ff;
	flag_state_s nxt_st;

	// Clear by writing ones; a new error in the same cycle still lands
	always_comb begin
		nxt_st = st_ff;
		nxt_st.flags = st_ff.flags & ~(clr_en ? clr_mask : '0); // R7 R11
		nxt_st.flags = nxt_st.flags | set_ev; // R6
	end

	// Flags start clear after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff.flags <= RST_ERR_FLAGS; // R10
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign flags = st_ff.flags;

endmodule

// [bench/reg_master.sv]
// Model of a system master on the register port: one-cycle strobes
// with a secure flag. Assumes one caller at a time on its tasks.
module reg_master
	import coh_regs_pkg::*;
(
	// Clock
	input  wire logic              clock,
	// Register port
	input  wire logic [DATA_W-1:0] rdata,
	output reg_req_s               req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// Released lines show the inverse so a stale value never passes
	task automatic idle(input reg_req_s r);
		req <= '{~r.addr, ~r.wdata, 1'b0, 1'b0, ~r.secure};
	endtask

	// Write: strobe, address, data and secure flag held one cycle
	task automatic wr(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic s);
		reg_req_s r;
		r = '{a, d, 1'b1, 1'b0, s};
		@(posedge clock);
		req <= r;
		@(posedge clock);
		idle(r);
	endtask

	// Read: data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic s,
		output logic [DATA_W-1:0] d);
		reg_req_s r;
		r = '{a, 32'h0000_0000, 1'b0, 1'b1, s};
		@(posedge clock);
		req <= r;
		@(posedge clock);
		idle(r);
		#1 d = rdata;
	endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the secure, status and error register bank.
// Assumes the package offsets and a 200 MHz clock.
module tb
	import coh_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clock;
	logic               resetn;
	logic               mod_pls;
	logic               app_pls;
	logic [NUM_SLV-1:0] snp_dis;
	logic [NUM_SLV-1:0] ac_out;
	err_event_s         err_ev;
	reg_req_s           req;
	logic [DATA_W-1:0]  rdata;
	logic [DATA_W-1:0]  d;
	logic               err_low;
	logic               irq;
	int                 num_errors;
	int                 n_tests;

	secure_status_error_regs dut_u (
		.clock(clock), .resetn(resetn), .req(req), .rdata(rdata),
		.enables_modified(mod_pls), .enables_applied(app_pls),
		.slave_snoop_disabled(snp_dis), .ac_outstanding(ac_out),
		.err_event(err_ev), .error_interrupt_low(err_low), .irq(irq)
	);

	reg_master m_u (.clock(clock), .rdata(rdata), .req(req));

	// Free-running 5 ns clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Verdict in one place
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Compare with four-state equality so unknowns fail
	task automatic check(input string what, input logic [DATA_W-1:0] got,
		input logic [DATA_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rchk(input string what, input logic [ADDR_W-1:0] a,
		input logic s, input logic [DATA_W-1:0] exp);
		m_u.rd(a, s, d);
		check(what, d, exp);
	endtask

	task automatic pin(input string what, input logic v, input logic exp);
		check(what, {31'h0, v}, {31'h0, exp});
	endtask

	// One-cycle pulses of error events and fabric handshakes
	task automatic ev(input err_event_s e, input logic m, input logic a);
		@(posedge clock);
		err_ev <= e;
		mod_pls <= m;
		app_pls <= a;
		@(posedge clock);
		err_ev <= '0;
		mod_pls <= 1'b0;
		app_pls <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Watchdog: a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge clock);
		num_errors++;
		report_and_stop;
	end

	initial begin
		resetn = 1'b0;
		mod_pls = 1'b0;
		app_pls = 1'b0;
		snp_dis = '0;
		ac_out = '0;
		err_ev = '0;
		num_errors = 0;
		n_tests = 0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		rchk("sec_ctrl rst", OFS_SEC_CTRL, 1'b1, 32'h0);
		rchk("status rst", OFS_STATUS, 1'b1, 32'h0);
		rchk("err_log rst", OFS_ERR_LOG, 1'b1, 32'h0);
		pin("err_low rst", err_low, 1'b1);
		$display("test reset done");
		// Non-secure error log traffic is shut out until the override opens it; non-secure control writes stay shut out
		m_u.wr(OFS_SEC_CTRL, 32'h1, 1'b0);
		rchk("sec_ctrl ns", OFS_SEC_CTRL, 1'b1, 32'h0);
		ev('1, 1'b0, 1'b0);
		tick(2);
		pin("err_low set", err_low, 1'b0);
		rchk("log ns", OFS_ERR_LOG, 1'b0, 32'h0);
		rchk("log all", OFS_ERR_LOG, 1'b1, 32'h001F_0007);
		m_u.wr(OFS_ERR_LOG, 32'hFFFF_FFFF, 1'b0);
		m_u.wr(OFS_ERR_LOG, 32'h0, 1'b1);
		rchk("log kept", OFS_ERR_LOG, 1'b1, 32'h001F_0007);
		m_u.wr(OFS_ERR_LOG, 32'h0001_0001, 1'b1);
		rchk("log w1c", OFS_ERR_LOG, 1'b1, 32'h001E_0006);
		m_u.wr(OFS_SEC_CTRL, 32'hFFFF_FFFF, 1'b1);
		rchk("sec_ctrl on", OFS_SEC_CTRL, 1'b0, 32'h1);
		m_u.wr(OFS_SEC_CTRL, 32'h0, 1'b0);
		rchk("sec_ctrl kept", OFS_SEC_CTRL, 1'b0, 32'h1);
		rchk("log open", OFS_ERR_LOG, 1'b0, 32'h001E_0006);
		m_u.wr(OFS_ERR_LOG, 32'hFFFF_FFFF, 1'b0);
		rchk("log clr", OFS_ERR_LOG, 1'b0, 32'h0);
		tick(2);
		pin("err_low clr", err_low, 1'b1);
		$display("test security done");
		// Pending bit follows enable changes and AC traffic
		m_u.wr(OFS_STATUS, 32'hFFFF_FFFF, 1'b1);
		rchk("status wi", OFS_STATUS, 1'b1, 32'h0);
		ev('0, 1'b1, 1'b0);
		rchk("pending", OFS_STATUS, 1'b1, 32'h1);
		ev('0, 1'b1, 1'b1);
		rchk("pending both", OFS_STATUS, 1'b1, 32'h1);
		ev('0, 1'b0, 1'b1);
		rchk("applied", OFS_STATUS, 1'b1, 32'h0);
		@(posedge clock);
		ac_out <= 5'h04;
		rchk("ac enabled", OFS_STATUS, 1'b1, 32'h0);
		@(posedge clock);
		snp_dis <= 5'h04;
		rchk("ac busy", OFS_STATUS, 1'b1, 32'h1);
		@(posedge clock);
		ac_out <= 5'h00;
		rchk("ac idle", OFS_STATUS, 1'b1, 32'h0);
		$display("test status done");
		// Maskable interrupt on error events
		m_u.wr(OFS_IRQ_STAT, 32'h3, 1'b1);
		m_u.wr(OFS_IRQ_MASK, 32'h1, 1'b1);
		tick(1);
		pin("irq idle", irq, 1'b0);
		ev('{slv: 5'h10, mst: 3'h4}, 1'b0, 1'b0);
		tick(1);
		pin("irq set", irq, 1'b1);
		rchk("log edge", OFS_ERR_LOG, 1'b1, 32'h0010_0004);
		m_u.wr(OFS_IRQ_STAT, 32'h1, 1'b1);
		tick(1);
		pin("irq clr", irq, 1'b0);
		pin("err_low held", err_low, 1'b0);
		m_u.wr(OFS_IRQ_MASK, 32'h0, 1'b1);
		ev('{slv: 5'h01, mst: 3'h0}, 1'b0, 1'b0);
		tick(1);
		pin("irq masked", irq, 1'b0);
		// Clearing write and a new error on the same edge: error wins
		fork
			m_u.wr(OFS_ERR_LOG, 32'h0011_0004, 1'b1);
			ev('{slv: 5'h10, mst: 3'h0}, 1'b0, 1'b0);
		join
		rchk("log tie", OFS_ERR_LOG, 1'b1, 32'h0010_0000);
		rchk("unmapped", 8'h20, 1'b1, 32'h0);
		$display("test interrupt done");
		report_and_stop;
	end
endmodule
